// File: common/pps_pkg.sv
// Purpose: Shared constants for the six-pin port with pin steering.
// Assumes: 32-bit Avalon-MM register bus with byte addresses.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package pps_pkg;

  localparam int PPS_ADDR_W = 8;
  localparam int PPS_PORT_W = 6;

  localparam logic [7:0] PPS_OFS_PIN_VALUE = 8'h00;
  localparam logic [7:0] PPS_OFS_DIRECTION = 8'h04;
  localparam logic [7:0] PPS_OFS_OUT_LATCH = 8'h08;
  localparam logic [7:0] PPS_OFS_ANALOG_SEL = 8'h0C;
  localparam logic [7:0] PPS_OFS_STEERING = 8'h10;

  localparam logic [5:0] PPS_DIR_RST = 6'h3F;
  localparam logic [5:0] PPS_LAT_RST = 6'h00;
  localparam logic [5:0] PPS_ANS_RST = 6'h17;
  localparam logic [7:0] PPS_STEER_RST = 8'h00;

  localparam logic [5:0] PPS_DIR_IMPL = 6'h37;
  localparam logic [5:0] PPS_LAT_IMPL = 6'h37;
  localparam logic [5:0] PPS_ANS_IMPL = 6'h17;
  localparam logic [7:0] PPS_STEER_IMPL = 8'h3B;
  localparam logic [5:0] PPS_INPUT_ONLY = 6'h08;

  localparam int PPS_BIT_INPUT_ONLY = 3;
  localparam int PPS_SEL_SERIAL_OUT = 5;
  localparam int PPS_SEL_SLAVE_SEL = 4;
  localparam int PPS_SEL_TIMER_GATE = 3;
  localparam int PPS_SEL_LOGIC_CELL = 1;
  localparam int PPS_SEL_OSC_GEN = 0;

  localparam logic PPS_WAIT_RST = 1'b1;

endpackage

// File: core/pps_sync.sv
// Purpose: Three-flop input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk.
// Notes: The output follows only when the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module pps_sync
  import pps_pkg::*;
#(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pps_sync_s;

  pps_sync_s r;
  pps_sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // The first stage is seen only by the second; metastability stays there.
    // Agreeing stages load the new level; disagreeing stages hold the old one.
    next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign dout = r.q;

endmodule
`default_nettype wire

// File: core/pps_pin_mux.sv
// Purpose: Output priority and pin steering for port A and port C overrides.
// Assumes: Peripheral enables are levels from same-clock logic.
// Notes: Purely combinational; the top registers every result.
`timescale 1ns/1ns
`default_nettype none
module pps_pin_mux
  import pps_pkg::*;
(
  input wire logic [5:0] latch,
  input wire logic [7:0] steer,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic logic_cell_output,
  input wire logic logic_cell_en,
  input wire logic osc_generator_output,
  input wire logic osc_generator_en,
  input wire logic comparator_out,
  input wire logic comparator_en,
  input wire logic pwm_out,
  input wire logic pwm_en,
  input wire logic clock_out,
  input wire logic clock_out_en,
  output logic [5:0] pa_value,
  output logic [5:0] pc_value,
  output logic [5:0] pc_en
);

  logic lc_on_pa;
  logic osc_on_pa;
  logic so_on_pa;

  always_comb begin
    lc_on_pa = logic_cell_en & ~steer[PPS_SEL_LOGIC_CELL]; // R18
    osc_on_pa = osc_generator_en & steer[PPS_SEL_OSC_GEN]; // R19
    so_on_pa = serial_out_en & steer[PPS_SEL_SERIAL_OUT]; // R15
    pa_value = latch;
    // Fixed priority, latch lowest; a peripheral takes the value only.
    if (lc_on_pa) begin // R21
      pa_value[2] = logic_cell_output;
    end else if (comparator_en) begin
      pa_value[2] = comparator_out;
    end else if (pwm_en) begin
      pa_value[2] = pwm_out;
    end
    if (clock_out_en) begin // R21
      pa_value[4] = clock_out;
    end else if (osc_on_pa) begin
      pa_value[4] = osc_generator_output;
    end else if (so_on_pa) begin
      pa_value[4] = serial_out;
    end
    pc_value = 6'h00;
    pc_en = 6'h00;
    pc_value[1] = osc_generator_output;
    pc_en[1] = osc_generator_en & ~steer[PPS_SEL_OSC_GEN]; // R19
    pc_value[2] = serial_out;
    pc_en[2] = serial_out_en & ~steer[PPS_SEL_SERIAL_OUT]; // R15
    pc_value[5] = logic_cell_output;
    pc_en[5] = logic_cell_en & steer[PPS_SEL_LOGIC_CELL]; // R18
  end

endmodule
`default_nettype wire

// File: core/pps_port.sv
// Purpose: Six-pin general purpose port with analog select and pin steering.
// Assumes: Avalon-MM slave, 32-bit data, one wait state per access.
// Notes: Port C overrides leave port C direction to its own port logic.
//
// Operation
// R1: Port A has six two-way pins with direction, latch and readback bits; the code makes bit 3 input only.
// R2: Direction 1 turns the driver off; 0 drives the latch value out.
// R3: Bit 3 is input only; its direction bit always reads 1.
// R4: Pin value reads give pin levels; writes store into the output latch.
// R5: Writing the output latch equals writing the pin value register.
// R6: Reading the output latch returns latch contents, not pin levels.
// R7: Pin value writes merge sampled pin levels with data into the latch.
// R8: Analog select disables the pin's digital input buffer.
// R9: Digital reads of analog pins return 0.
// R10: Direction still controls the driver while a pin is analog.
// R11: Analog select never affects digital output drive.
// R12: Implemented analog select bits reset to 1.
// R13: An enabled peripheral owns the pin value; the pin stays readable.
// R14: Steering never alters direction; overrides reach only the chosen pin.
// R15: Steering bit 5 puts serial out on port A bit 4, else port C bit 2.
// R16: Steering bit 4 takes slave select from port A bit 3, else port C bit 3.
// R17: Steering bit 3 takes timer gate from port A bit 3, else bit 4.
// R18: Steering bit 1 puts logic cell on port C bit 5, else port A bit 2.
// R19: Steering bit 0 puts oscillator on port A bit 4, else port C bit 1.
// R20: Steering bits 7, 6, 2 read 0; implemented bits reset to 0.
// R21: Highest priority enabled output owns a pin; the latch is lowest.
// R22: Implemented direction bits reset to 1.
// R23: Pin inputs are synchronised before reads and merges.
`timescale 1ns/1ns
`default_nettype none
module pps_port
  import pps_pkg::*;
#(
  parameter int ADDR_W = PPS_ADDR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [5:0] pa_in,
  output logic [5:0] pa_out,
  output logic [5:0] pa_oe,
  input wire logic pc_bit3_in,
  output logic [5:0] pc_override_value,
  output logic [5:0] pc_override_en,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic logic_cell_output,
  input wire logic logic_cell_en,
  input wire logic osc_generator_output,
  input wire logic osc_generator_en,
  input wire logic comparator_out,
  input wire logic comparator_en,
  input wire logic pwm_out,
  input wire logic pwm_en,
  input wire logic clock_out,
  input wire logic clock_out_en,
  output logic timer_gate_input,
  output logic slave_select_input_n
);

  typedef struct packed {
    logic [5:0] direction;
    logic [5:0] latch;
    logic [5:0] analog_sel;
    logic [7:0] steering;
    logic wait_busy;
    logic [31:0] rdata;
    logic [5:0] out_val;
    logic [5:0] out_en;
    logic [5:0] pc_val;
    logic [5:0] pc_en;
    logic tgate;
    logic ss_n;
  } pps_port_s;

  pps_port_s r;
  pps_port_s next_r;

  logic [6:0] pin_sync;
  logic [5:0] pa_sync;
  logic pc3_sync;
  logic [5:0] pa_digital;
  logic [5:0] mux_pa;
  logic [5:0] mux_pc_val;
  logic [5:0] mux_pc_en;
  logic [7:0] word_ofs;
  logic req;
  logic [5:0] merged;

  // R23
  pps_sync #(
    .W(7)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .din({pc_bit3_in, pa_in}),
    .dout(pin_sync)
  );

  assign pa_sync = pin_sync[5:0];
  assign pc3_sync = pin_sync[6];

  pps_pin_mux u_mux (
    .latch(r.latch),
    .steer(r.steering),
    .serial_out(serial_out),
    .serial_out_en(serial_out_en),
    .logic_cell_output(logic_cell_output),
    .logic_cell_en(logic_cell_en),
    .osc_generator_output(osc_generator_output),
    .osc_generator_en(osc_generator_en),
    .comparator_out(comparator_out),
    .comparator_en(comparator_en),
    .pwm_out(pwm_out),
    .pwm_en(pwm_en),
    .clock_out(clock_out),
    .clock_out_en(clock_out_en),
    .pa_value(mux_pa),
    .pc_value(mux_pc_val),
    .pc_en(mux_pc_en)
  );

  always_comb begin
    next_r = r;
    word_ofs = 8'h00;
    word_ofs[ADDR_W-1:2] = address[ADDR_W-1:2];
    req = read | write;
    // Analog pins have their input buffer off and read as zero.
    pa_digital = pa_sync & ~r.analog_sel; // R8 R9
    // With the low lane disabled a pin value write keeps sampled levels.
    merged = byteenable[0] ? writedata[5:0] : pa_digital; // R7

    // One wait state: the answer is prepared, then taken at the next edge.
    if (req && r.wait_busy) begin
      next_r.wait_busy = 1'b0;
      next_r.rdata = 32'h0000_0000;
      if (read) begin
        case (word_ofs)
          PPS_OFS_PIN_VALUE: next_r.rdata[5:0] = pa_digital; // R4 R13
          PPS_OFS_DIRECTION: next_r.rdata[5:0] = r.direction | PPS_INPUT_ONLY; // R3
          PPS_OFS_OUT_LATCH: next_r.rdata[5:0] = r.latch; // R6
          PPS_OFS_ANALOG_SEL: next_r.rdata[5:0] = r.analog_sel;
          PPS_OFS_STEERING: next_r.rdata[7:0] = r.steering; // R20
          default: next_r.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      next_r.wait_busy = PPS_WAIT_RST;
      if (write && !r.wait_busy) begin
        case (word_ofs)
          PPS_OFS_PIN_VALUE: begin
            next_r.latch = merged & PPS_LAT_IMPL; // R4 R7
          end
          PPS_OFS_OUT_LATCH: begin
            next_r.latch = merged & PPS_LAT_IMPL; // R5
          end
          PPS_OFS_DIRECTION: begin
            if (byteenable[0]) begin
              next_r.direction = (writedata[5:0] & PPS_DIR_IMPL) | PPS_INPUT_ONLY; // R3
            end
          end
          PPS_OFS_ANALOG_SEL: begin
            if (byteenable[0]) begin
              next_r.analog_sel = writedata[5:0] & PPS_ANS_IMPL;
            end
          end
          PPS_OFS_STEERING: begin
            if (byteenable[0]) begin
              next_r.steering = writedata[7:0] & PPS_STEER_IMPL; // R20
            end
          end
          default: begin
            next_r.latch = r.latch;
          end
        endcase
      end
    end

    // Driver follows direction only; analog select and steering never touch it.
    next_r.out_en = ~r.direction & ~PPS_INPUT_ONLY; // R2 R10 R11 R14
    next_r.out_val = mux_pa; // R2 R13 R21
    next_r.pc_val = mux_pc_val; // R14
    next_r.pc_en = mux_pc_en; // R14

    if (r.steering[PPS_SEL_TIMER_GATE]) begin // R17
      next_r.tgate = pa_digital[3];
    end else begin
      next_r.tgate = pa_digital[4];
    end
    if (r.steering[PPS_SEL_SLAVE_SEL]) begin // R16
      next_r.ss_n = pa_digital[3];
    end else begin
      next_r.ss_n = pc3_sync;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r.direction <= PPS_DIR_RST; // R22
      r.latch <= PPS_LAT_RST;
      r.analog_sel <= PPS_ANS_RST; // R12
      r.steering <= PPS_STEER_RST; // R20
      r.wait_busy <= PPS_WAIT_RST;
      r.rdata <= 32'h0000_0000;
      r.out_val <= 6'h00;
      r.out_en <= 6'h00;
      r.pc_val <= 6'h00;
      r.pc_en <= 6'h00;
      r.tgate <= 1'b0;
      r.ss_n <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign readdata = r.rdata;
  assign waitrequest = r.wait_busy;
  assign pa_out = r.out_val; // R1
  assign pa_oe = r.out_en;
  assign pc_override_value = r.pc_val;
  assign pc_override_en = r.pc_en;
  assign timer_gate_input = r.tgate;
  assign slave_select_input_n = r.ss_n;

endmodule
`default_nettype wire

// File: test/pps_port_properties.sv
// Purpose: Bus and pin properties of the six-pin port.
// Assumes: Bound to pps_port; sees its ports only.
// Notes: Read checks use readdata at the edge where waitrequest is low.
`timescale 1ns/1ns
`default_nettype none
module pps_port_properties
  import pps_pkg::*;
#(
  parameter int ADDR_W = PPS_ADDR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [5:0] pa_oe,
  input wire logic [5:0] pc_override_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_done(logic [7:0] ofs);
    ce && read && !waitrequest && address == ofs;
  endsequence
  bus_answer_a: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered");
  in_only_a: assert property (pa_oe[3] == 1'b0)
    else $error("input-only pin driven");
  dir_read_a: assert property (rd_done(PPS_OFS_DIRECTION) |-> readdata[3])
    else $error("direction bit 3 read low");
  steer_read_a: assert property (rd_done(PPS_OFS_STEERING) |-> readdata[7:6] == 2'h0 && !readdata[2])
    else $error("unimplemented steering bit set");
  lat_read_a: assert property (rd_done(PPS_OFS_OUT_LATCH) |-> readdata[31:6] == 26'h0 && !readdata[3])
    else $error("unimplemented latch bit set");
  ans_read_a: assert property (rd_done(PPS_OFS_ANALOG_SEL) |-> readdata[31:5] == 27'h0 && !readdata[3])
    else $error("unimplemented analog bit set");
  oe_follow_a: assert property (ce && write && !waitrequest && byteenable[0] && address == PPS_OFS_DIRECTION |-> ##2 pa_oe == (6'(~$past(writedata, 2)) & PPS_DIR_IMPL))
    else $error("driver enable does not follow direction");
  pc_bits_a: assert property ((pc_override_en & 6'h19) == 6'h00)
    else $error("override on a pin that is never steered");
endmodule
`default_nettype wire

// File: test/pps_pin_model.sv
// Purpose: Pin model resolving port A and port C bit 3 levels.
// Assumes: A driven pin shows the drive value, else the outside level.
// Notes: Outside levels come from the bench.
`timescale 1ns/1ns
`default_nettype none
module pps_pin_model (
  input wire logic [5:0] pa_out,
  input wire logic [5:0] pa_oe,
  input wire logic [5:0] ext_a,
  input wire logic ext_c3,
  output logic [5:0] pa_in,
  output logic pc_bit3_in
);
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pc_bit3_in = ext_c3;
endmodule
`default_nettype wire

// File: test/tb_pps_port.sv
// Purpose: Self-checking bench for the six-pin port.
// Assumes: ce held active; byteenable lane 0 is cleared for one write only.
// Notes: Pin changes get six edges to pass the synchroniser.
`timescale 1ns/1ns
`default_nettype none
module tb_pps_port import pps_pkg::*;;
  logic clk, read = 0, write = 0, ext_c3 = 0, pc3, tg, ss_n, wt, nrst = 0, ce = 1;
  logic [7:0] address = 0;
  logic [31:0] writedata = 0, readdata;
  logic [3:0] byteenable = 4'h1;
  logic [5:0] pa_in, pa_out, pa_oe, pc_v, pc_en, ext_a = 0;
  logic [11:0] per = 0;
  int failures = 0, compares = 0;
  pps_port u_pps_port (.clk(clk), .nrst(nrst), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(wt), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pc_bit3_in(pc3),
    .pc_override_value(pc_v), .pc_override_en(pc_en), .serial_out(per[0]),
    .serial_out_en(per[1]), .logic_cell_output(per[2]), .logic_cell_en(per[3]),
    .osc_generator_output(per[4]), .osc_generator_en(per[5]), .comparator_out(per[6]),
    .comparator_en(per[7]), .pwm_out(per[8]), .pwm_en(per[9]), .clock_out(per[10]),
    .clock_out_en(per[11]), .timer_gate_input(tg), .slave_select_input_n(ss_n));
  pps_pin_model u_pps_pin_model (.pa_out(pa_out), .pa_oe(pa_oe), .ext_a(ext_a),
    .ext_c3(ext_c3), .pa_in(pa_in), .pc_bit3_in(pc3));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waitrequest and readdata are registered, so after an edge they still show
  // the values that edge sampled; the watchdog ends a wait that never finishes.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (wt !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    rd(PPS_OFS_DIRECTION, 8'h3F);
    rd(PPS_OFS_ANALOG_SEL, 8'h17);
    rd(PPS_OFS_STEERING, 8'h00);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_dir();
    wr(PPS_OFS_DIRECTION, 8'h00);
    rd(PPS_OFS_DIRECTION, 8'h08);
    wr(PPS_OFS_OUT_LATCH, 8'hFF);
    rd(PPS_OFS_OUT_LATCH, 8'h37);
    settle();
    chk(32'(pa_out), 32'h37);
    chk(32'(pa_oe), 32'h37);
    $display("direction done");
  endtask
  task automatic t_analog();
    rd(PPS_OFS_PIN_VALUE, 8'h20);
    wr(PPS_OFS_DIRECTION, 8'h3F);
    ext_a <= 6'h3F;
    settle();
    chk(32'(pa_oe), 32'h00);
    rd(PPS_OFS_PIN_VALUE, 8'h28);
    wr(PPS_OFS_ANALOG_SEL, 8'h00);
    rd(PPS_OFS_PIN_VALUE, 8'h3F);
    $display("analog done");
  endtask
  task automatic t_latch();
    wr(PPS_OFS_PIN_VALUE, 8'h00);
    rd(PPS_OFS_OUT_LATCH, 8'h00);
    wr(PPS_OFS_OUT_LATCH, 8'h15);
    rd(PPS_OFS_PIN_VALUE, 8'h3F);
    rd(PPS_OFS_OUT_LATCH, 8'h15);
    byteenable <= 4'h0;
    wr(PPS_OFS_PIN_VALUE, 8'h00);
    byteenable <= 4'h1;
    rd(PPS_OFS_OUT_LATCH, 8'h37);
    $display("latch done");
  endtask
  task automatic t_steer();
    wr(PPS_OFS_DIRECTION, 8'h00);
    ext_a <= 6'h08;
    per <= 12'h03F;
    wr(PPS_OFS_OUT_LATCH, 8'h00);
    wr(PPS_OFS_STEERING, 8'hFF);
    rd(PPS_OFS_STEERING, 8'h3B);
    settle();
    chk(32'(pa_out), 32'h10);
    chk(32'(pc_en), 32'h20);
    chk(32'(pa_oe), 32'h37);
    chk({30'h0, tg, ss_n}, 32'h3);
    rd(PPS_OFS_PIN_VALUE, 8'h18);
    rd(PPS_OFS_DIRECTION, 8'h08);
    wr(PPS_OFS_STEERING, 8'h00);
    settle();
    chk(32'(pa_out), 32'h04);
    chk(32'(pc_v & pc_en), 32'h06);
    chk({30'h0, tg, ss_n}, 32'h0);
    wr(PPS_OFS_STEERING, 8'h03);
    per <= 12'hAF0;
    settle();
    chk(32'(pa_out), 32'h04);
    @(posedge clk);
    per <= 12'h230;
    settle();
    chk(32'(pa_out), 32'h10);
    $display("steering done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_dir();
    t_analog();
    t_latch();
    t_steer();
    report_and_stop();
  end
endmodule
bind pps_port pps_port_properties #(.ADDR_W(ADDR_W)) u_pps_port_properties (.clk(clk),
  .nrst(nrst), .ce(ce), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .pa_oe(pa_oe), .pc_override_en(pc_override_en));
`default_nettype wire
